// file: src/panel_ctrl_regs.vh
// Constants for the servo front-panel diagnostic and jog controller
`ifndef PANEL_CTRL_REGS_VH
`define PANEL_CTRL_REGS_VH

// Register indices (word address = index)
`define REG_CTRL        4'h0
`define REG_PARAM_IDX   4'h1
`define REG_PARAM_DATA  4'h2
`define REG_JOG_SPEED   4'h3
`define REG_JOG_ACCEL   4'h4
`define REG_FORCE_OUT   4'h5
`define REG_STATUS      4'h6
`define REG_DIAG        4'h7

// Control register fields
`define CTRL_LINK_JOG   0
`define CTRL_LINK_OK    1
`define CTRL_LINK_DIR   2
`define CTRL_LINK_RUN   3

// Parameter numbers
`define PAR_CTRL_MODE   6'h00
`define PAR_WR_DISABLE  6'h13
`define PAR_IO_FIRST    6'h2B
`define PAR_IO_LAST     6'h31
`define PAR_BASIC_LAST  6'h13
`define PAR_LAST        6'h31
`define PAR_WR_OPEN     16'h000E

// Jog defaults and limits
`define JOG_SPEED_DEF   16'h00C8
`define JOG_ACCEL_DEF   16'h03E8
`define JOG_ACCEL_MAX   16'hC350
`define JOG_SPEED_MAX   16'h1770

// Timing
`define CLK_HZ          20000000
`define SET_HOLD_MS     2000
`define DEBOUNCE_US     10000
`define SET_HOLD_CYC    (`CLK_HZ / 1000 * `SET_HOLD_MS)
`define DEBOUNCE_CYC    (`CLK_HZ / 1000000 * `DEBOUNCE_US)

// Screens
`define SCR_PARAM       3'h0
`define SCR_DIAG        3'h1
`define SCR_FORCE       3'h2
`define SCR_JOG_READY   3'h3
`define SCR_STATUS      3'h4
`define STATUS_SCREENS  4'h8

`endif

// file: src/servo_panel_diag_jog_ctrl.v
// Front-panel parameter, I/O diagnostic, forced output and jog controller
`timescale 1ns/1ns
`include "panel_ctrl_regs.vh"

module servo_panel_diag_jog_ctrl #(
   parameter SET_HOLD_CYC = `SET_HOLD_CYC,
   parameter DEBOUNCE_CYC = `DEBOUNCE_CYC
) (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   input  wire        btn_mode,
   input  wire        btn_up,
   input  wire        btn_down,
   input  wire        btn_set,
   input  wire        in_pin3,
   input  wire        servo_on_in,
   input  wire        in_pin5,
   input  wire        fwd_stroke_end_in,
   input  wire        rev_stroke_end_in,
   input  wire        emergency_stop_in,
   input  wire        ext_cmd_active,
   input  wire        core_alarm,
   input  wire        core_ready,
   input  wire        core_in_pos,
   input  wire        core_speed_lim,
   input  wire        core_zero_speed,
   input  wire        core_z_phase,
   output reg         trouble_out,
   output reg         pin10_out,
   output reg         ready_out,
   output reg         pin12_out,
   output reg         encoder_index_out,
   output reg         fault_reset_in_act,
   output reg         clear_droop_act,
   output reg         fwd_start_act,
   output reg         rev_start_act,
   output reg         speed_mode_q,
   output reg  [7:0]  seg_upper,
   output reg  [7:0]  seg_lower,
   output reg  [2:0]  screen_q,
   output reg  [3:0]  status_idx_q,
   output reg  [5:0]  param_sel_q,
   output reg         jog_run_q,
   output reg         jog_ccw_q,
   output reg         jog_decel_q,
   output reg  [15:0] jog_speed_q,
   output reg  [15:0] jog_accel_q
);

////////////////////////////////////////////////////////////////////////////////
// Button conditioning

function [15:0] clamp16;
   input [15:0] v;
   input [15:0] mx;
   begin
      clamp16 = (v > mx) ? mx : v;
   end
endfunction

reg  [3:0]  btn_s1_q;
reg  [3:0]  btn_s2_q;
reg  [3:0]  btn_db_q;
reg  [3:0]  btn_prev_q;
reg  [31:0] db_cnt_q;
wire [3:0]  btn_raw = {btn_set, btn_down, btn_up, btn_mode};
wire [3:0]  btn_rise = btn_db_q & ~btn_prev_q;

always @(posedge sys_clk or negedge rst_n) begin
   if (!rst_n) begin
      btn_s1_q   <= 4'h0;
      btn_s2_q   <= 4'h0;
      btn_db_q   <= 4'h0;
      btn_prev_q <= 4'h0;
      db_cnt_q   <= 32'h0;
   end else begin
      btn_s1_q   <= btn_raw;
      btn_s2_q   <= btn_s1_q;
      btn_prev_q <= btn_db_q;
      if (btn_s2_q == btn_db_q) begin
         db_cnt_q <= 32'h0;
      end else if (db_cnt_q >= DEBOUNCE_CYC - 1) begin
         btn_db_q <= btn_s2_q;
         db_cnt_q <= 32'h0;
      end else begin
         db_cnt_q <= db_cnt_q + 32'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Parameter store

reg  [15:0] param_mem [0:63];
reg  [15:0] mode_saved_q;
reg  [5:0]  idx_q;
reg         boot_q;
wire        expansion_open = (param_mem[`PAR_WR_DISABLE] == `PAR_WR_OPEN);
wire        idx_ok = (reg_addr == `REG_PARAM_DATA) &&
                     (idx_q <= `PAR_BASIC_LAST || (expansion_open && idx_q <= `PAR_LAST));
wire        servo_mode_live = (mode_saved_q != 16'h0000);

always @(posedge sys_clk) begin
   if (reg_wr && idx_ok) begin
      param_mem[idx_q] <= reg_wdata;
   end
end

// Power-up latch of control mode
always @(posedge sys_clk or negedge rst_n) begin
   if (!rst_n) begin
      boot_q       <= 1'b1;
      speed_mode_q <= 1'b0;
      mode_saved_q <= 16'h0000;
   end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
         mode_saved_q <= param_mem[`PAR_CTRL_MODE];
         speed_mode_q <= param_mem[`PAR_CTRL_MODE] != 16'h0000;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Screens, jog and forced output

reg  [31:0] set_cnt_q;
reg         set_armed_q;
reg  [7:0]  force_q;
reg  [3:0]  ctrl_q;
wire        test_ok = !servo_on_in;
wire        jog_ok = test_ok && !ext_cmd_active;
wire        link_jog = ctrl_q[`CTRL_LINK_JOG];

always @(posedge sys_clk or negedge rst_n) begin
   if (!rst_n) begin
      screen_q     <= `SCR_PARAM;
      status_idx_q <= 4'h0;
      param_sel_q  <= 6'h00;
      set_cnt_q    <= 32'h0;
      set_armed_q  <= 1'b0;
      jog_run_q    <= 1'b0;
      jog_ccw_q    <= 1'b0;
      jog_decel_q  <= 1'b0;
   end else begin
      if (btn_rise[0]) begin
         case (screen_q)
            `SCR_PARAM:     screen_q <= `SCR_DIAG;
            `SCR_DIAG:      screen_q <= `SCR_FORCE;
            `SCR_FORCE:     screen_q <= test_ok ? `SCR_JOG_READY : `SCR_PARAM;
            `SCR_JOG_READY: begin
               screen_q     <= `SCR_STATUS;
               status_idx_q <= 4'h0;
               set_armed_q  <= 1'b1;
            end
            `SCR_STATUS: begin
               if (status_idx_q == `STATUS_SCREENS - 4'h1) begin
                  screen_q <= `SCR_JOG_READY;
               end else begin
                  status_idx_q <= status_idx_q + 4'h1;
               end
            end
            default:        screen_q <= `SCR_PARAM;
         endcase
      end
      if (screen_q == `SCR_PARAM && !btn_db_q[0]) begin
         if (btn_rise[1] && param_sel_q < `PAR_BASIC_LAST) begin
            param_sel_q <= param_sel_q + 6'h01;
         end else if (btn_rise[2] && param_sel_q != 6'h00) begin
            param_sel_q <= param_sel_q - 6'h01;
         end
      end
      // SET hold ends the jog session
      if (set_armed_q && btn_db_q[3] &&
          (screen_q == `SCR_STATUS || screen_q == `SCR_JOG_READY)) begin
         if (set_cnt_q >= SET_HOLD_CYC - 1) begin
            screen_q    <= `SCR_PARAM;
            set_armed_q <= 1'b0;
            set_cnt_q   <= 32'h0;
         end else begin
            set_cnt_q <= set_cnt_q + 32'h1;
         end
      end else begin
         set_cnt_q <= 32'h0;
      end
      // Jog drive; UP or DOWN held alone runs the jog here (UP sets CCW) unless link jog is set
      if ((screen_q == `SCR_JOG_READY || screen_q == `SCR_STATUS) && jog_ok) begin
         if (link_jog) begin
            if (!ctrl_q[`CTRL_LINK_OK] && jog_run_q) begin
               jog_decel_q <= 1'b1;
               jog_run_q   <= 1'b0;
            end else if (ctrl_q[`CTRL_LINK_OK]) begin
               jog_run_q   <= ctrl_q[`CTRL_LINK_RUN];
               jog_ccw_q   <= ctrl_q[`CTRL_LINK_DIR];
               jog_decel_q <= 1'b0;
            end
         end else begin
            jog_run_q   <= btn_db_q[1] ^ btn_db_q[2];
            jog_ccw_q   <= btn_db_q[1];
            jog_decel_q <= 1'b0;
         end
      end else begin
         jog_decel_q <= jog_run_q;
         jog_run_q   <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Register port

always @(posedge sys_clk or negedge rst_n) begin
   if (!rst_n) begin
      idx_q       <= 6'h00;
      ctrl_q      <= 4'h0;
      force_q     <= 8'h00;
      jog_speed_q <= `JOG_SPEED_DEF;
      jog_accel_q <= `JOG_ACCEL_DEF;
      reg_rdata   <= 16'h0000;
   end else begin
      reg_rdata <= 16'h0000;
      if (reg_wr) begin
         case (reg_addr)
            `REG_CTRL:      ctrl_q      <= reg_wdata[3:0];
            `REG_PARAM_IDX: idx_q       <= reg_wdata[5:0];
            `REG_JOG_SPEED: jog_speed_q <= clamp16(reg_wdata, `JOG_SPEED_MAX);
            `REG_JOG_ACCEL: jog_accel_q <= clamp16(reg_wdata, `JOG_ACCEL_MAX);
            `REG_FORCE_OUT: force_q     <= reg_wdata[7:0];
            default:        idx_q       <= idx_q;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL:       reg_rdata <= {12'h000, ctrl_q};
            `REG_PARAM_IDX:  reg_rdata <= {10'h000, idx_q};
            `REG_PARAM_DATA: reg_rdata <= idx_ok ? param_mem[idx_q] : 16'h0000;
            `REG_JOG_SPEED:  reg_rdata <= jog_speed_q;
            `REG_JOG_ACCEL:  reg_rdata <= jog_accel_q;
            `REG_FORCE_OUT:  reg_rdata <= {8'h00, force_q};
            `REG_STATUS:     reg_rdata <= {8'h00, expansion_open, speed_mode_q, jog_decel_q,
                                           jog_ccw_q, jog_run_q, screen_q};
            `REG_DIAG:       reg_rdata <= {seg_upper, seg_lower};
            default:         reg_rdata <= 16'h0000;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// I/O mapping, forced output and diagnostic segments

wire       forcing = (screen_q == `SCR_FORCE) && !servo_on_in;
wire       pin10_nat = speed_mode_q ? core_speed_lim : core_in_pos;
wire [4:0] out_nat = {core_z_phase, core_zero_speed, core_ready, pin10_nat, core_alarm};
wire [4:0] out_now = forcing ? force_q[4:0] : out_nat;

always @(posedge sys_clk or negedge rst_n) begin
   if (!rst_n) begin
      trouble_out        <= 1'b0;
      pin10_out          <= 1'b0;
      ready_out          <= 1'b0;
      pin12_out          <= 1'b0;
      encoder_index_out  <= 1'b0;
      fault_reset_in_act <= 1'b0;
      clear_droop_act    <= 1'b0;
      fwd_start_act      <= 1'b0;
      rev_start_act      <= 1'b0;
      seg_upper          <= 8'h00;
      seg_lower          <= 8'h00;
   end else begin
      {encoder_index_out, pin12_out, ready_out, pin10_out, trouble_out} <= out_now;
      fault_reset_in_act <= !servo_mode_live && in_pin3;
      clear_droop_act    <= !servo_mode_live && in_pin5;
      fwd_start_act      <= servo_mode_live && in_pin3;
      rev_start_act      <= servo_mode_live && in_pin5;
      // Default assignment order
      seg_upper <= {2'b00, emergency_stop_in, rev_stroke_end_in, fwd_stroke_end_in,
                    in_pin5, servo_on_in, in_pin3};
      seg_lower <= {3'b000, out_now};
   end
end

endmodule // servo_panel_diag_jog_ctrl

// file: tb/servo_panel_diag_jog_ctrl_checker.sv
// Assertion checker for the panel controller
`timescale 1ns/1ns
module panel_checker (
   input wire        sys_clk,
   input wire        rst_n,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   input wire        btn_mode,
   input wire        btn_up,
   input wire        btn_down,
   input wire        btn_set,
   input wire        in_pin3,
   input wire        servo_on_in,
   input wire        ext_cmd_active,
   input wire        core_in_pos,
   input wire        core_speed_lim,
   input wire        pin10_out,
   input wire        fwd_start_act,
   input wire        speed_mode_q,
   input wire [7:0]  seg_upper,
   input wire [2:0]  screen_q,
   input wire [3:0]  status_idx_q,
   input wire        jog_run_q,
   input wire        jog_ccw_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   reg [1:0] age_q;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         age_q <= 2'h0;
      else if (age_q != 2'h3)
         age_q <= age_q + 2'h1;
   end
   wire jog_ok = !servo_on_in && !ext_cmd_active && screen_q == 3'h3;
   sequence up_held;
      (btn_up && !btn_down && jog_ok) [*8];
   endsequence
   sequence dn_held;
      (btn_down && !btn_up && jog_ok) [*8];
   endsequence
   a_mode_power_latch: assert property (age_q == 2'h3 |-> $stable(speed_mode_q))
      else $error("mode changed without power cycle");
   a_up_runs_ccw: assert property (up_held |-> jog_run_q && jog_ccw_q)
      else $error("held up not ccw");
   a_down_runs_cw: assert property (dn_held |-> jog_run_q && !jog_ccw_q)
      else $error("held down not cw");
   a_ext_blocks_jog: assert property (ext_cmd_active [*4] |-> !jog_run_q)
      else $error("jog with external command");
   a_servo_refuse: assert property ((screen_q == 3'h2 && servo_on_in) [*4] ##1 screen_q != 3'h2
      |-> screen_q == 3'h0) else $error("test mode entered with servo on");
   a_status_hold: assert property ((screen_q == 3'h4 && !btn_mode && !btn_set) [*8]
      |-> $stable(status_idx_q)) else $error("status screen moved");
   a_status_wrap: assert property (screen_q == 3'h4 && status_idx_q == 4'h7 && !btn_set
      ##1 screen_q != 3'h4 |-> screen_q == 3'h3) else $error("status wrap wrong");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside slot");
   a_pin10_map: assert property ((screen_q != 3'h2 && (speed_mode_q ? core_speed_lim : core_in_pos)) [*4]
      |-> pin10_out) else $error("pin10 source wrong");
   a_fwd_start: assert property ((speed_mode_q && in_pin3) [*4] |-> fwd_start_act)
      else $error("forward start not decoded");
   a_pos_no_start: assert property (!speed_mode_q |-> !fwd_start_act)
      else $error("start decoded in position mode");
   a_seg_servo: assert property (servo_on_in [*4] |-> seg_upper[1])
      else $error("servo-on segment dark");
endmodule // panel_checker
bind servo_panel_diag_jog_ctrl panel_checker chk_i (.*);

// file: tb/panel_operator.sv
// Operator button and host discrete I/O model
`timescale 1ns/1ns
module panel_operator (
   input  wire sys_clk,
   output wire btn_mode,
   output wire btn_up,
   output wire btn_down,
   output wire btn_set,
   output wire in_pin3,
   output wire servo_on_in,
   output wire in_pin5,
   output wire fwd_stroke_end_in,
   output wire rev_stroke_end_in,
   output wire emergency_stop_in,
   output wire ext_cmd_active,
   output wire core_alarm,
   output wire core_ready,
   output wire core_in_pos,
   output wire core_speed_lim,
   output wire core_zero_speed,
   output wire core_z_phase
);
   reg [3:0] btn_q  = 4'h0;
   reg [5:0] pin_q  = 6'h20; // Stop input tied to common
   reg [5:0] core_q = 6'h00;
   reg       ext_q  = 1'b0;
   assign {btn_set, btn_down, btn_up, btn_mode} = btn_q;
   assign {emergency_stop_in, rev_stroke_end_in, fwd_stroke_end_in, in_pin5, servo_on_in, in_pin3} = pin_q;
   assign {core_z_phase, core_zero_speed, core_ready, core_speed_lim, core_in_pos, core_alarm} = core_q;
   assign ext_cmd_active = ext_q;
   task press(input [3:0] b);
      btn_q <= b;
   endtask
   task push(input [3:0] b);
      begin
         btn_q <= b;
         repeat (8) @(posedge sys_clk); // Outlasts sync and debounce
         #1 btn_q <= 4'h0;
         repeat (8) @(posedge sys_clk);
         #1;
      end
   endtask
   task host(input [5:0] p, input [5:0] c, input e);
      begin
         pin_q <= p;
         core_q <= c;
         ext_q <= e;
      end
   endtask
endmodule // panel_operator

// file: tb/servo_panel_diag_jog_ctrl_tb.sv
// Self-checking bench for the panel controller
`timescale 1ns/1ns
`include "panel_ctrl_regs.vh"
module servo_panel_diag_jog_ctrl_tb;
   reg         sys_clk   = 1'b0;
   reg         rst_n     = 1'b0;
   reg  [3:0]  reg_addr  = 4'h0;
   reg  [15:0] reg_wdata = 16'h0000;
   reg         reg_wr    = 1'b0;
   reg         reg_rd    = 1'b0;
   wire [15:0] reg_rdata, jog_speed_q, jog_accel_q;
   wire [7:0]  seg_upper, seg_lower;
   wire [5:0]  param_sel_q;
   wire [3:0]  status_idx_q;
   wire [2:0]  screen_q;
   wire        trouble_out, pin10_out, ready_out, pin12_out, encoder_index_out, fault_reset_in_act;
   wire        clear_droop_act, fwd_start_act, rev_start_act, speed_mode_q, jog_run_q, jog_ccw_q, jog_decel_q;
   wire        btn_mode, btn_up, btn_down, btn_set, in_pin3, servo_on_in, in_pin5, fwd_stroke_end_in;
   wire        rev_stroke_end_in, emergency_stop_in, ext_cmd_active, core_alarm, core_ready;
   wire        core_in_pos, core_speed_lim, core_zero_speed, core_z_phase;
   integer     errors      = 0;
   integer     comparisons = 0;
   integer     i;
   always #25 sys_clk = ~sys_clk;
   servo_panel_diag_jog_ctrl #(.SET_HOLD_CYC(200), .DEBOUNCE_CYC(2)) uut (.*);
   panel_operator op (.*);
   ////////////////////////////////////////////////////////////////////////
   task cyc(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   task chk(input string name, input [15:0] exp, input [15:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("FAIL %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         cyc(1);
         reg_wr <= 1'b0;
         cyc(1);
      end
   endtask
   task rdc(input [3:0] a, input [15:0] e);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         cyc(1);
         reg_rd <= 1'b0;
         chk("reg_rdata", e, reg_rdata);
         cyc(1);
      end
   endtask
   task final_report;
      begin
         $display("errors %0d comparisons %0d", errors, comparisons);
         if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      errors = errors + 1;
      final_report;
   end
   initial begin
      cyc(4);
      rst_n <= 1'b1;
      cyc(2);
      wr(`REG_PARAM_IDX, 16'h0013);
      wr(`REG_PARAM_DATA, 16'h0000);
      wr(`REG_PARAM_IDX, 16'h0000);
      wr(`REG_PARAM_DATA, 16'h0000);
      rst_n <= 1'b0; // Power cycle with a known store
      cyc(2);
      rst_n <= 1'b1;
      cyc(2);
      chk("jog_speed_q", `JOG_SPEED_DEF, jog_speed_q);
      rdc(`REG_JOG_ACCEL, `JOG_ACCEL_DEF);
      wr(`REG_JOG_ACCEL, 16'hFFFF);
      rdc(`REG_JOG_ACCEL, `JOG_ACCEL_MAX);
      wr(`REG_JOG_SPEED, 16'h1771);
      rdc(`REG_JOG_SPEED, `JOG_SPEED_MAX);
      rdc(4'hF, 16'h0000);
      wr(`REG_PARAM_IDX, 16'h0014);
      wr(`REG_PARAM_DATA, 16'h1234);
      rdc(`REG_PARAM_DATA, 16'h0000);
      wr(`REG_PARAM_IDX, 16'h0013);
      wr(`REG_PARAM_DATA, `PAR_WR_OPEN);
      wr(`REG_PARAM_IDX, 16'h0014);
      wr(`REG_PARAM_DATA, 16'h1234);
      rdc(`REG_PARAM_DATA, 16'h1234);
      op.push(4'h2);
      chk("param_sel_q", 16'h0001, {10'h000, param_sel_q});
      op.push(4'h4);
      chk("param_sel_q", 16'h0000, {10'h000, param_sel_q});
      op.host(6'h25, 6'h1A, 1'b0);
      op.push(4'h1);
      chk("seg_upper", 16'h0025, {8'h00, seg_upper});
      chk("seg_lower", 16'h000E, {8'h00, seg_lower});
      chk("in_act", 16'h000C, {12'h000, fault_reset_in_act, clear_droop_act, fwd_start_act, rev_start_act});
      op.push(4'h1);
      wr(`REG_FORCE_OUT, 16'h0015);
      cyc(3);
      chk("outs", 16'h0015, {11'h000, encoder_index_out, pin12_out, ready_out, pin10_out, trouble_out});
      op.host(6'h27, 6'h1A, 1'b0);
      cyc(6);
      chk("outs", 16'h000E, {11'h000, encoder_index_out, pin12_out, ready_out, pin10_out, trouble_out});
      op.push(4'h1);
      chk("screen_q", 16'h0000, {13'h0000, screen_q});
      op.host(6'h25, 6'h1A, 1'b1);
      for (i = 0; i < 3; i = i + 1)
         op.push(4'h1);
      chk("screen_q", 16'h0003, {13'h0000, screen_q});
      op.press(4'h2);
      cyc(10);
      chk("jog_run_q", 16'h0000, {15'h0000, jog_run_q});
      op.host(6'h25, 6'h1A, 1'b0);
      cyc(10);
      chk("jog_dir", 16'h0003, {14'h0000, jog_run_q, jog_ccw_q});
      op.press(4'h4);
      cyc(10);
      chk("jog_dir", 16'h0002, {14'h0000, jog_run_q, jog_ccw_q});
      op.press(4'h0);
      cyc(10);
      chk("jog_run_q", 16'h0000, {15'h0000, jog_run_q});
      op.push(4'h1);
      op.push(4'h2);
      chk("status_idx_q", 16'h0000, {12'h000, status_idx_q});
      for (i = 1; i < 8; i = i + 1)
         op.push(4'h1);
      chk("status_idx_q", 16'h0007, {12'h000, status_idx_q});
      op.push(4'h1);
      chk("screen_q", 16'h0003, {13'h0000, screen_q});
      wr(`REG_CTRL, 16'h000B);
      cyc(3);
      chk("jog_run_q", 16'h0001, {15'h0000, jog_run_q});
      wr(`REG_CTRL, 16'h0009);
      cyc(3);
      chk("jog_decel_q", 16'h0001, {15'h0000, jog_decel_q});
      wr(`REG_CTRL, 16'h0000);
      op.push(4'h1);
      op.press(4'h8);
      cyc(150);
      chk("screen_q", 16'h0004, {13'h0000, screen_q});
      cyc(110);
      op.press(4'h0);
      cyc(10);
      chk("screen_q", 16'h0000, {13'h0000, screen_q});
      wr(`REG_PARAM_IDX, 16'h0000);
      wr(`REG_PARAM_DATA, 16'h0001);
      cyc(2);
      chk("speed_mode_q", 16'h0000, {15'h0000, speed_mode_q});
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(8);
      chk("speed_mode_q", 16'h0001, {15'h0000, speed_mode_q});
      chk("fwd_start_act", 16'h0001, {15'h0000, fwd_start_act});
      chk("pin10_out", 16'h0000, {15'h0000, pin10_out});
      chk("in_act", 16'h0003, {12'h000, fault_reset_in_act, clear_droop_act, fwd_start_act, rev_start_act});
      rdc(`REG_STATUS, 16'h00C0);
      op.host(6'h1A, 6'h25, 1'b0);
      cyc(6);
      chk("outs", 16'h0013, {11'h000, encoder_index_out, pin12_out, ready_out, pin10_out, trouble_out});
      chk("in_act", 16'h0000, {12'h000, fault_reset_in_act, clear_droop_act, fwd_start_act, rev_start_act});
      rdc(`REG_DIAG, 16'h1A13);
      final_report;
   end
endmodule // servo_panel_diag_jog_ctrl_tb
